// ### dv/ref_clock_source.sv
// reference master clock source model for the clock generation bench
`timescale 1ns/10ps
module ref_clock_source (
    input wire logic clk, // system clock
    input wire logic [7:0] half_period, // half period in clk cycles
    output logic ref_clk_in // reference level, changes at falling edge
);
    logic [7:0] cnt_reg;

    initial begin
        cnt_reg = 8'h00;
        ref_clk_in = 1'b0;
    end

    // free running, as a crystal source is; slow enough for the sampler
    always @(negedge clk) begin
        if (cnt_reg + 8'h01 >= half_period) begin
            cnt_reg <= 8'h00;
            ref_clk_in <= ~ref_clk_in;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule : ref_clock_source

// ### dv/testbench.sv
// self-checking bench for the clock generation and loopback block
`timescale 1ns/10ps
module testbench;
    import clkgen_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic reg_we = 1'b0;
    logic gp_en = 1'b0;
    logic pin_in = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [8:0] reg_wdata = 9'h000;
    logic [8:0] reg_rdata;
    logic ref_clk_in, core_clock, core_tick, synth_running, pin_out, pin_oe, sel_in;
    logic [23:0] cap_if_out = 24'h0, cap_src = 24'h0, play_if_out = 24'h0, play_src = 24'h0;
    logic [23:0] cap_if_in, play_data_in;
    integer n_fail = 0;
    integer tests_run = 0;
    integer seed = 32'hdbec;
    integer cycles = 0;
    int ticks, togs, n, ctogs;
    logic [8:0] v;
    logic [8:0] kept;
    logic [6:0] addrs [7] = '{7'h01, 7'h05, 7'h06, 7'h24, 7'h25, 7'h26, 7'h27};
    logic [8:0] rstv [7] = '{9'h000, 9'h000, 9'h140, 9'h04C, 9'h00C, 9'h093, 9'h0E9};
    int halves [8] = '{2, 3, 4, 6, 8, 12, 16, 24};

    always #5 clk = ~clk;

    ref_clock_source ref_src (.clk(clk), .half_period(8'h10), .ref_clk_in(ref_clk_in));

    clock_gen_loopback #(.DATA_W(24)) dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata), .ref_clk_in(ref_clk_in),
        .core_clock(core_clock), .core_tick(core_tick), .synth_running(synth_running),
        .gp_clock_out_en(gp_en), .select_or_gp_pin_in(pin_in), .select_or_gp_pin_out(pin_out),
        .select_or_gp_pin_oe(pin_oe), .select_input(sel_in), .cap_if_out(cap_if_out),
        .cap_src(cap_src), .play_if_out(play_if_out), .play_src(play_src),
        .cap_if_in(cap_if_in), .play_data_in(play_data_in));

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check

    // tick counts drift by the phase of the reference against the window
    task automatic check_near(input string name, input int exp, input int got, input int tol);
        tests_run++;
        if (got < exp - tol || got > exp + tol) begin
            n_fail++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask : check_near

    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        @(negedge clk);
        reg_we = 1'b0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [8:0] d);
        reg_addr = a;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd

    task automatic count(input int win, output int tk, output int tg);
        logic last;
        logic lastc;
        tk = 0;
        tg = 0;
        ctogs = 0;
        repeat (64) @(negedge clk);
        last = pin_out;
        lastc = core_clock;
        repeat (win) begin
            @(negedge clk);
            tk += (core_tick === 1'b1);
            tg += (pin_out !== last);
            ctogs += (core_clock !== lastc);
            last = pin_out;
            lastc = core_clock;
        end
    endtask : count

    // expected core ticks on the synthesizer path, divide 1 after the fixed /4
    function automatic int exp_synth(input int pre, input int nn, input longint k, input int win);
        longint ev;
        ev = win / (16 << pre);
        return int'(((longint'(nn) * 64'h100_0000 + k) * ev) >> 26);
    endfunction : exp_synth

    always @(posedge clk) begin
        cycles++;
        if (cycles >= 60000) begin
            n_fail++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(addrs[i], v);
            check("reset_value", rstv[i], v);
        end
        rd(7'h10, v);
        check("unmapped_read", 9'h000, v);
        $display("test register reset done");
        for (int i = 0; i < 7; i++) begin
            n = $random(seed);
            wr(addrs[i], n[8:0]);
            if (i == 4) begin
                kept = n[8:0];
            end
            rd(addrs[i], v);
            check("reg_readback", n[8:0], v);
        end
        ce = 1'b0;
        wr(7'h25, ~kept);
        ce = 1'b1;
        rd(7'h25, v);
        check("ce_low_write", kept, v);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rd(7'h24, v);
        check("mid_reset_value", 9'h04C, v);
        $display("test register access done");
        for (int i = 0; i < 24; i++) begin
            n = $random(seed);
            wr(7'h01, n[8:0]);
            wr(7'h24, {n[12:9], 1'b0, 4'h8});
            check("synth_running", n[5] & |n[1:0] & ~n[11], synth_running);
        end
        $display("test synth enable done");
        for (int m = 0; m < 4; m++) begin
            wr(7'h05, {2'b00, m[1], 5'h00, m[0]});
            repeat (4) begin
                n = $random(seed);
                {cap_if_out, pin_in} = {n[23:0], n[31]};
                n = $random(seed);
                cap_src = n[23:0];
                play_if_out = ~n[23:0];
                play_src = {n[11:0], n[23:12]};
                @(negedge clk);
                check("cap_if_in", m[1] ? play_if_out : cap_src, cap_if_in);
                check("play_data_in", m[0] ? cap_if_out : play_src, play_data_in);
                check("select_input", pin_in, sel_in);
            end
        end
        $display("test loopback done");
        for (int c = 0; c < 8; c++) begin
            wr(7'h06, {1'b0, c[2:0], 5'h00});
            count(1536, ticks, togs);
            check_near("ref_div_ticks", 96 / halves[c], ticks, 1);
            check_near("core_clock_toggles", 96 / halves[c], ctogs, 1);
        end
        $display("test reference divider done");
        gp_en = 1'b1;
        wr(7'h01, 9'h021);
        wr(7'h06, 9'h100);
        wr(7'h25, 9'h000);
        wr(7'h26, 9'h000);
        wr(7'h27, 9'h000);
        for (int p = 0; p < 4; p++) begin
            n = 5 + ($unsigned($random(seed)) % 8);
            wr(7'h24, {3'b001, p[1:0], n[3:0]});
            count(2048, ticks, togs);
            check_near("synth_core_ticks", exp_synth(p, n, 0, 2048), ticks, 3);
            check("pin_toggling", 1, togs > 0);
            check("pin_oe", 1'b1, pin_oe);
        end
        wr(7'h25, 9'h020);
        for (int fe = 1; fe >= 0; fe--) begin
            wr(7'h24, {2'b00, fe[0], 2'b01, 4'h6});
            count(2048, ticks, togs);
            check_near("frac_core_ticks", exp_synth(1, 6, fe * 64'h80_0000, 2048), ticks, 3);
        end
        wr(7'h24, 9'h098);
        count(2048, ticks, togs);
        check("shutdown_ticks", 0, ticks);
        check("shutdown_pin", 0, togs);
        wr(7'h24, 9'h058);
        wr(7'h01, 9'h020);
        count(1024, ticks, togs);
        check("midrail_off_ticks", 0, ticks);
        check("midrail_off_pin", 1'b0, pin_out);
        $display("test synthesizer path done");
        finish_test();
    end
endmodule : testbench

// ### hdl/clkgen_pkg.sv
// constants for the clock generation and loopback block
package clkgen_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int REG_W = 9;
    localparam logic [6:0] POWER_MANAGEMENT_ONE_ADDR = 7'h01;
    localparam logic [6:0] COMPANDING_CTRL_ADDR = 7'h05;
    localparam logic [6:0] CLOCK_GEN_CTRL_ADDR = 7'h06;
    localparam logic [6:0] SYNTH_INTEGER_CTRL_ADDR = 7'h24;
    localparam logic [6:0] SYNTH_FRACTION_HIGH_ADDR = 7'h25;
    localparam logic [6:0] SYNTH_FRACTION_MID_ADDR = 7'h26;
    localparam logic [6:0] SYNTH_FRACTION_LOW_ADDR = 7'h27;

    // reset values
    localparam logic [8:0] POWER_MANAGEMENT_ONE_RST = 9'h000;
    localparam logic [8:0] COMPANDING_CTRL_RST = 9'h000;
    localparam logic [8:0] CLOCK_GEN_CTRL_RST = 9'h140;
    localparam logic [8:0] SYNTH_INTEGER_CTRL_RST = 9'h04C;
    localparam logic [8:0] SYNTH_FRACTION_HIGH_RST = 9'h00C;
    localparam logic [8:0] SYNTH_FRACTION_MID_RST = 9'h093;
    localparam logic [8:0] SYNTH_FRACTION_LOW_RST = 9'h0E9;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SYNTH_ON_BIT_POS = 5;
    localparam int MIDRAIL_SELECT_LSB = 0;
    localparam int SYNTH_SHUTDOWN_POS = 7;
    localparam int FRACTIONAL_MODE_ENABLE_POS = 6;
    localparam int REF_PRESCALE_SEL_LSB = 4;
    localparam int RATIO_INTEGER_LSB = 0;
    localparam int CORE_CLOCK_SOURCE_POS = 8;
    localparam int SYSTEM_DIVIDER_LSB = 5;
    localparam int PLAY_LOOPBACK_POS = 6;
    localparam int CAPTURE_LOOPBACK_POS = 0;

    // ----------------------------------------------------------------
    // ratio arithmetic and dividers
    // ----------------------------------------------------------------
    localparam int FRAC_W = 24;
    localparam int RATIO_W = 28;
    localparam int CREDIT_W = 32;
    localparam logic [31:0] CREDIT_ONE = 32'h0100_0000;
    localparam logic [1:0] POST_DIV_LAST = 2'h3; // fixed divide by 4
    localparam logic [4:0] HALF_STEP = 5'h02;

    typedef enum logic [1:0] {PRE_DOUBLE, PRE_NONE, PRE_HALF, PRE_QUARTER} prescale_t;

    // divider in half-cycle units: 1,1.5,2,3,4,6,8,12
    function automatic logic [4:0] div_halves(input logic [2:0] code);
        case (code)
            3'h0: div_halves = 5'h02;
            3'h1: div_halves = 5'h03;
            3'h2: div_halves = 5'h04;
            3'h3: div_halves = 5'h06;
            3'h4: div_halves = 5'h08;
            3'h5: div_halves = 5'h0C;
            3'h6: div_halves = 5'h10;
            default: div_halves = 5'h18;
        endcase
    endfunction : div_halves
endpackage : clkgen_pkg

// ### hdl/clock_gen_loopback.sv
// register-controlled clock synthesizer, core clock divider and digital loopback
`timescale 1ns/10ps

// Contract
// - synthesizer runs when the on bit is 1 and shutdown bit 7 of integer control is 0, off at 0; resets to 0.
// - midrail select of 00b holds the synthesizer off whatever the on bit.
// - ratio is integer field plus fraction field.
// - synthesizer output goes through fixed /4 then system divider to core clock.
// - synthesizer clock can be driven out on the select or general pin.
// - fractional mode bit 6 enables fractional part; resets to 1.
// - prescale 00 doubles, 01 passes, 10 halves, 11 quarters the reference.
// - fraction is high six, mid nine, low nine bits concatenated.
// - capture loopback feeds capture interface output into playback input.
// - playback loopback feeds playback interface output into capture input.
// - source bit 8 picks reference at 0, synthesizer at 1; resets to 1.
// - system divider codes select 1,1.5,2,3,4,6,8,12; resets to 010.
// - loopbacks sit at bits 6 and 0 of companding control, reset off.
module clock_gen_loopback #(
    parameter int DATA_W = 24 // audio word width
) (
    input wire logic clk, // system clock, 100 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic [clkgen_pkg::ADDR_W-1:0] reg_addr, // register address
    input wire logic [clkgen_pkg::REG_W-1:0] reg_wdata, // register write data
    input wire logic reg_we, // register write strobe
    output logic [clkgen_pkg::REG_W-1:0] reg_rdata, // registered read data
    input wire logic ref_clk_in, // reference master clock, sampled
    output logic core_clock, // divided core clock level
    output logic core_tick, // one-cycle pulse per core clock toggle, two per core clock period
    output logic synth_running, // synthesizer enabled
    input wire logic gp_clock_out_en, // route synth clock onto pin
    input wire logic select_or_gp_pin_in, // pin input level
    output logic select_or_gp_pin_out, // pin output level
    output logic select_or_gp_pin_oe, // pin output enable
    output logic select_input, // pin level seen as select input
    input wire logic [DATA_W-1:0] cap_if_out, // capture interface output data
    input wire logic [DATA_W-1:0] cap_src, // normal capture interface input
    input wire logic [DATA_W-1:0] play_if_out, // playback interface output data
    input wire logic [DATA_W-1:0] play_src, // normal playback data input
    output logic [DATA_W-1:0] cap_if_in, // data into capture interface
    output logic [DATA_W-1:0] play_data_in // data into playback path
);
    import clkgen_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [8:0] pm1;
        logic [8:0] comp;
        logic [8:0] cgen;
        logic [8:0] intc;
        logic [8:0] frh;
        logic [8:0] frm;
        logic [8:0] frl;
        logic [8:0] rdata;
        logic ref_q;
        logic [1:0] pre_cnt;
        logic [CREDIT_W-1:0] credit;
        logic synth_tick;
        logic [1:0] post_cnt;
        logic post_tick;
        logic gp_clk;
        logic core_clk;
        logic [DATA_W-1:0] cap_in;
        logic [DATA_W-1:0] play_in;
    } state_t;

    state_t st_reg, st_next;

    logic synth_en;
    logic ref_rise;
    logic ref_edge;
    logic pre_event;
    logic [RATIO_W-1:0] ratio;
    logic [FRAC_W-1:0] fraction;
    logic div_in;
    logic div_out;
    prescale_t pre_sel;

    // ----------------------------------------------------------------
    // decoded controls
    // ----------------------------------------------------------------
    assign synth_en = st_reg.pm1[SYNTH_ON_BIT_POS]
        && (st_reg.pm1[MIDRAIL_SELECT_LSB +: 2] != 2'h0)
        && !st_reg.intc[SYNTH_SHUTDOWN_POS];
    assign fraction = {st_reg.frh[5:0], st_reg.frm, st_reg.frl};
    // fraction ignored in integer mode, matching the low-power setting
    assign ratio = {st_reg.intc[RATIO_INTEGER_LSB +: 4],
        st_reg.intc[FRACTIONAL_MODE_ENABLE_POS] ? fraction : {FRAC_W{1'b0}}};
    assign pre_sel = prescale_t'(st_reg.intc[REF_PRESCALE_SEL_LSB +: 2]);
    assign ref_rise = ref_clk_in && !st_reg.ref_q;
    assign ref_edge = ref_clk_in != st_reg.ref_q;

    // reference conditioning; doubling counts both edges
    always_comb begin
        unique case (pre_sel)
            PRE_DOUBLE: pre_event = ref_edge;
            PRE_NONE: pre_event = ref_rise;
            PRE_HALF: pre_event = ref_rise && st_reg.pre_cnt[0];
            PRE_QUARTER: pre_event = ref_rise && (st_reg.pre_cnt == 2'h3);
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [CREDIT_W-1:0] cr;
        cr = st_reg.credit;
        st_next = st_reg;
        st_next.ref_q = ref_clk_in;
        if (ref_rise) begin
            st_next.pre_cnt = st_reg.pre_cnt + 2'h1;
        end
        // register writes
        if (reg_we) begin
            unique case (reg_addr)
                POWER_MANAGEMENT_ONE_ADDR: st_next.pm1 = reg_wdata;
                COMPANDING_CTRL_ADDR: st_next.comp = reg_wdata;
                CLOCK_GEN_CTRL_ADDR: st_next.cgen = reg_wdata;
                SYNTH_INTEGER_CTRL_ADDR: st_next.intc = reg_wdata;
                SYNTH_FRACTION_HIGH_ADDR: st_next.frh = reg_wdata;
                SYNTH_FRACTION_MID_ADDR: st_next.frm = reg_wdata;
                SYNTH_FRACTION_LOW_ADDR: st_next.frl = reg_wdata;
                default: ;
            endcase
        end
        unique case (reg_addr)
            POWER_MANAGEMENT_ONE_ADDR: st_next.rdata = st_reg.pm1;
            COMPANDING_CTRL_ADDR: st_next.rdata = st_reg.comp;
            CLOCK_GEN_CTRL_ADDR: st_next.rdata = st_reg.cgen;
            SYNTH_INTEGER_CTRL_ADDR: st_next.rdata = st_reg.intc;
            SYNTH_FRACTION_HIGH_ADDR: st_next.rdata = st_reg.frh;
            SYNTH_FRACTION_MID_ADDR: st_next.rdata = st_reg.frm;
            SYNTH_FRACTION_LOW_ADDR: st_next.rdata = st_reg.frl;
            default: st_next.rdata = 9'h000;
        endcase
        // synthesizer: each conditioned reference event earns ratio credit,
        // each whole unit of credit is one output tick; output rate is capped
        // at the system clock, so ratios must keep the product below 100 MHz
        st_next.synth_tick = 1'b0;
        if (!synth_en) begin
            cr = '0;
        end else begin
            if (pre_event) begin
                cr = cr + {{(CREDIT_W-RATIO_W){1'b0}}, ratio};
            end
            if (cr >= CREDIT_ONE) begin
                cr = cr - CREDIT_ONE;
                st_next.synth_tick = 1'b1;
            end
        end
        st_next.credit = cr;
        // fixed divide by 4 after the synthesizer
        st_next.post_tick = 1'b0;
        if (!synth_en) begin
            st_next.post_cnt = 2'h0;
            st_next.gp_clk = 1'b0;
        end else if (st_reg.synth_tick) begin
            st_next.post_cnt = st_reg.post_cnt + 2'h1;
            st_next.post_tick = st_reg.post_cnt == POST_DIV_LAST;
            st_next.gp_clk = st_reg.gp_clk ^ st_reg.post_cnt[1] ^ st_next.post_cnt[1];
        end
        if (div_out) begin
            st_next.core_clk = !st_reg.core_clk;
        end
        // loopback steering, registered
        st_next.play_in = st_reg.comp[CAPTURE_LOOPBACK_POS] ? cap_if_out : play_src;
        st_next.cap_in = st_reg.comp[PLAY_LOOPBACK_POS] ? play_if_out : cap_src;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.pm1 <= POWER_MANAGEMENT_ONE_RST;
            st_reg.comp <= COMPANDING_CTRL_RST;
            st_reg.cgen <= CLOCK_GEN_CTRL_RST;
            st_reg.intc <= SYNTH_INTEGER_CTRL_RST;
            st_reg.frh <= SYNTH_FRACTION_HIGH_RST;
            st_reg.frm <= SYNTH_FRACTION_MID_RST;
            st_reg.frl <= SYNTH_FRACTION_LOW_RST;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // core clock source and system divider
    // ----------------------------------------------------------------
    assign div_in = st_reg.cgen[CORE_CLOCK_SOURCE_POS] ? st_reg.post_tick : ref_rise;

    half_step_divider u_sysdiv (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .tick_in(div_in),
        .halves(div_halves(st_reg.cgen[SYSTEM_DIVIDER_LSB +: 3])),
        .tick_out(div_out)
    );

    assign core_tick = div_out;
    assign core_clock = st_reg.core_clk;
    assign synth_running = synth_en;
    assign reg_rdata = st_reg.rdata;
    assign select_or_gp_pin_oe = gp_clock_out_en;
    assign select_or_gp_pin_out = st_reg.gp_clk;
    assign select_input = select_or_gp_pin_in;
    assign cap_if_in = st_reg.cap_in;
    assign play_data_in = st_reg.play_in;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_synth_off_bit: assert property (@(posedge clk) disable iff (rst)
        ce && !st_reg.pm1[SYNTH_ON_BIT_POS] |=> !st_reg.synth_tick)
        else $error("synth tick with on bit clear");
    a_midrail_off: assert property (@(posedge clk) disable iff (rst)
        ce && st_reg.pm1[1:0] == 2'h0 |=> st_reg.credit == '0 && !st_reg.synth_tick)
        else $error("synth active with midrail zero");
    a_no_core_off: assert property (@(posedge clk) disable iff (rst)
        (!synth_en && ce) [*3] |=> !st_reg.post_tick)
        else $error("derived clock while synth off");
    a_post_div4: assert property (@(posedge clk) disable iff (rst)
        st_reg.post_tick && $past(ce)
            |-> $past(st_reg.synth_tick) && $past(st_reg.post_cnt) == 2'h3)
        else $error("post divide not by four");
    a_frac_ignored: assert property (@(posedge clk) disable iff (rst)
        !st_reg.intc[FRACTIONAL_MODE_ENABLE_POS] |-> ratio[FRAC_W-1:0] == '0)
        else $error("fraction used in integer mode");
    a_frac_concat: assert property (@(posedge clk) disable iff (rst)
        st_reg.intc[FRACTIONAL_MODE_ENABLE_POS] |-> ratio[23:18] == st_reg.frh[5:0]
            && ratio[8:0] == st_reg.frl && ratio[27:24] == st_reg.intc[3:0])
        else $error("ratio assembly wrong");
    a_cap_loop: assert property (@(posedge clk) disable iff (rst)
        ce && st_reg.comp[0] |=> play_data_in == $past(cap_if_out))
        else $error("capture loopback data wrong");
    a_play_loop: assert property (@(posedge clk) disable iff (rst)
        ce && !st_reg.comp[6] |=> cap_if_in == $past(cap_src))
        else $error("capture input not from normal source");
    a_quarter_pre: assert property (@(posedge clk) disable iff (rst)
        pre_sel == PRE_QUARTER && pre_event |-> st_reg.pre_cnt == 2'h3 && ref_rise)
        else $error("quarter prescale event misplaced");
    a_source_ref: assert property (@(posedge clk) disable iff (rst)
        !st_reg.cgen[8] && ref_rise |-> div_in)
        else $error("reference not routed to divider");
endmodule : clock_gen_loopback

// ### hdl/half_step_divider.sv
// tick divider with half-step ratios for the core clock
`timescale 1ns/10ps
module half_step_divider (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic ce, // clock enable
    input wire logic tick_in, // one-cycle input event
    input wire logic [4:0] halves, // ratio in half units
    output logic tick_out // one-cycle output event
);
    import clkgen_pkg::*;

    typedef struct packed {
        logic [5:0] acc;
        logic tick;
    } div_state_t;

    div_state_t st_reg, st_next;

    // each input adds two halves; reaching or passing the ratio emits a tick
    always_comb begin
        logic [5:0] sum;
        sum = 6'h00;
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (tick_in) begin
            sum = st_reg.acc + {1'b0, HALF_STEP};
            if (sum >= {1'b0, halves}) begin
                st_next.acc = sum - {1'b0, halves};
                st_next.tick = 1'b1;
            end else begin
                st_next.acc = sum;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign tick_out = st_reg.tick;
endmodule : half_step_divider
